/* File: lms_host_model.sv */
`timescale 1ns/1ps
module lms_host_model (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Reply handshake
   input wire logic REPLY_GO,
   input wire logic SLOW,
   output logic REPLY_DONE
);
   int cnt = 0;
   // ----------
   // Line time of a reply, prompt or slow
   // ----------
   always @(posedge SYS_CLK) begin
      REPLY_DONE <= !SYS_RST && !REPLY_GO && cnt == 1;
      if (SYS_RST) cnt <= 0;
      else if (REPLY_GO) cnt <= SLOW ? 20 : 2;
      else if (cnt > 0) cnt <= cnt - 1;
   end
endmodule

/* File: lms_pkg.sv */
package lms_pkg;

   // ----------
   // Clock and time base
   // ----------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned MS_TIME_US = 1000;
   localparam int unsigned MS_CYC_DEF = CLK_HZ / 1_000_000 * MS_TIME_US;
   localparam int unsigned WD_STEP_MS = 100;
   localparam int unsigned SEC_STEPS = 10;
   localparam int unsigned OVERSAMPLE = 16;

   // ----------
   // Baud table
   // ----------
   localparam int unsigned BAUD_1200 = 1200;
   localparam int unsigned BAUD_2400 = 2400;
   localparam int unsigned BAUD_4800 = 4800;
   localparam int unsigned BAUD_9600 = 9600;
   localparam int unsigned BAUD_19200 = 19200;
   localparam int unsigned BAUD_38400 = 38400;
   localparam int unsigned BAUD_57600 = 57600;
   localparam int unsigned BAUD_115200 = 115200;
   localparam logic [5:0] BAUD_CODE_MIN = 6'h03;
   localparam logic [5:0] BAUD_CODE_MAX = 6'h0A;

   // ----------
   // Register and coil addresses
   // ----------
   localparam logic [15:0] A_RELAY = 16'h0001;
   localparam logic [15:0] A_SILENCE = 16'h0021;
   localparam logic [15:0] A_SAFE = 16'h0081;
   localparam logic [15:0] A_CLR_HI = 16'h0118;
   localparam logic [15:0] A_CLR_LO = 16'h0119;
   localparam logic [15:0] A_RES = 16'h7531;
   localparam logic [15:0] A_POT = 16'h7535;
   localparam logic [15:0] A_HI = 16'h7731;
   localparam logic [15:0] A_LO = 16'h7751;
   localparam logic [15:0] A_FW_LO = 16'h9E21;
   localparam logic [15:0] A_FW_HI = 16'h9E22;
   localparam logic [15:0] A_NAME_LO = 16'h9E23;
   localparam logic [15:0] A_NAME_HI = 16'h9E24;
   localparam logic [15:0] A_STATION = 16'h9E25;
   localparam logic [15:0] A_SERIAL = 16'h9E26;
   localparam logic [15:0] A_RDLY = 16'h9E28;
   localparam logic [15:0] A_WD_TO = 16'h9E29;
   localparam logic [15:0] A_WD_CNT = 16'h9E2C;
   localparam logic [15:0] A_THR = 16'h9E30;
   localparam logic [15:0] A_BEEP = 16'h9E31;
   localparam int unsigned N_SENSORS = 4;

   // ----------
   // Limits and reset values
   // ----------
   localparam logic [15:0] STATION_MIN = 16'h0001;
   localparam logic [15:0] STATION_MAX = 16'h00F7;
   localparam logic [15:0] RDLY_MAX = 16'h001E;
   localparam logic [15:0] WD_TO_MAX = 16'h00FF;
   localparam logic [15:0] THR_MAX = 16'h0018;
   localparam logic [15:0] BEEP_MAX_TIMED = 16'h00FA;
   localparam logic [15:0] BEEP_CONT = 16'h00FB;
   localparam logic [7:0] STATION_RST = 8'h01;
   localparam logic [7:0] SERIAL_RST = 8'h06;
   localparam logic [15:0] LO_LATCH_RST = 16'hFFFF;
   localparam int unsigned FMT_CKS_BIT = 6;

   typedef enum logic [1:0] {
      RP_IDLE = 2'b01,
      RP_WAIT = 2'b10
   } lms_reply_t;

endpackage

/* File: lms_regmap.sv */
`timescale 1ns/1ps
// Function
// - Serial bits 5:0 pick baud rate
// - Serial bits 7:6 pick parity and stops
// - Frame format bit 6 enables checksums
// - Station address 1..247, match only it
// - Reply waits 0..30 ms delay
// - Watchdog timeout 0..255 in 0.1 s
// - Count watchdog expiries, write zero clears
// - Leak threshold index 0..24
// - Beep off, 1..250 s, or continuous
// - Report potentiometer threshold index read-only
// - Report four sensor resistances read-only
// - High latch keeps largest reading
// - Low latch keeps smallest reading
// - Firmware version, low word first
// - Module name, low word first
// - Coil drives relay output
// - Separate coil holds relay safe value
// - Silence switch readable as one bit
// - Writing one clears all high latches
// - Writing one clears all low latches
module lms_regmap #(
   parameter int unsigned MS_CYC = lms_pkg::MS_CYC_DEF,
   // Identity words: values are arbitrary
   parameter logic [31:0] FW_VERSION = 32'h0001_0000,
   parameter logic [31:0] MODULE_NAME = 32'h0000_0ABC
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Register access from the frame engine
   input wire logic REG_REQ,
   input wire logic REG_WE,
   input wire logic [15:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   output logic REG_ACK,
   output logic REG_ERR,
   output logic [15:0] REG_RDATA,
   // Frame addressing and reply timing
   input wire logic [7:0] FRAME_ADDR,
   output logic FRAME_ADDR_MATCH,
   input wire logic REPLY_READY,
   output logic REPLY_GO,
   input wire logic REPLY_DONE,
   // Serial line configuration
   input wire logic [7:0] FRAME_FORMAT,
   output logic BAUD_TICK,
   output logic PARITY_EN,
   output logic PARITY_ODD,
   output logic STOP_TWO,
   output logic CHECKSUM_EN,
   // Host watchdog
   input wire logic HOST_ACTIVITY,
   output logic WDOG_EXPIRED,
   // Sensing
   input wire logic [3:0][15:0] SENSOR_RES,
   input wire logic SENSOR_VALID,
   input wire logic [4:0] POT_INDEX,
   output logic [4:0] LEAK_THRESHOLD,
   // Alarm, beeper and relay
   input wire logic ALARM,
   input wire logic SILENCE_SW,
   output logic BEEP,
   output logic RELAY_OUT
);
   import lms_pkg::*;

   // ----------
   // State
   // ----------
   typedef struct packed {
      logic [15:0] rdata;
      logic ack;
      logic err;
      logic [7:0] st_addr;
      logic [7:0] serial_act;
      logic [7:0] serial_pend;
      logic pend;
      logic [4:0] rdly;
      logic [7:0] wd_to;
      logic [15:0] wd_cnt;
      logic [4:0] thr;
      logic [7:0] beep_dur;
      logic relay;
      logic safe;
      logic [3:0][15:0] res;
      logic [3:0][15:0] hi;
      logic [3:0][15:0] lo;
      logic [16:0] ms_pre;
      logic [6:0] step_ms;
      logic [3:0] sec_steps;
      logic [7:0] wd_steps;
      logic wd_exp;
      logic [12:0] baud_cnt;
      logic baud_tick;
      lms_reply_t rp;
      logic [16:0] rd_pre;
      logic [4:0] rd_ms;
      logic reply_go;
      logic match;
      logic cks;
      logic alarm_q;
      logic [7:0] beep_left;
   } lms_state_t;

   lms_state_t s;
   lms_state_t n;
   logic tick_ms;
   logic tick_step;
   logic tick_sec;

   // ----------
   // Helpers
   // ----------
   function automatic logic [12:0] baud_div(input logic [5:0] code);
      int unsigned b;
      unique case (code)
         6'h03: b = BAUD_1200;
         6'h04: b = BAUD_2400;
         6'h05: b = BAUD_4800;
         6'h06: b = BAUD_9600;
         6'h07: b = BAUD_19200;
         6'h08: b = BAUD_38400;
         6'h09: b = BAUD_57600;
         6'h0A: b = BAUD_115200;
         default: b = BAUD_9600;
      endcase
      return 13'(CLK_HZ / (OVERSAMPLE * b) - 1);
   endfunction

   // Four-word block starting at base
   function automatic logic in_block(input logic [15:0] a,
                                     input logic [15:0] base);
      return (a >= base) && (a < base + 16'(N_SENSORS));
   endfunction

   // ----------
   // Next state
   // ----------
   always_comb begin
      n = s;
      n.ack = 1'b0;
      n.err = 1'b0;
      n.rdata = 16'h0000;
      n.baud_tick = 1'b0;
      n.reply_go = 1'b0;

      // Shared time base: ms, 100 ms step, second
      tick_ms = (s.ms_pre == 17'(MS_CYC - 1));
      tick_step = tick_ms && (s.step_ms == 7'(WD_STEP_MS - 1));
      tick_sec = tick_step && (s.sec_steps == 4'(SEC_STEPS - 1));
      n.ms_pre = tick_ms ? 17'h00000 : s.ms_pre + 17'h00001;
      if (tick_ms) begin
         n.step_ms = tick_step ? 7'h00 : s.step_ms + 7'h01;
      end
      if (tick_step) begin
         n.sec_steps = tick_sec ? 4'h0 : s.sec_steps + 4'h1;
      end

      // Register access
      if (REG_REQ) begin
         n.ack = 1'b1;
         if (REG_WE) begin
            unique case (REG_ADDR)
               A_RELAY: begin
                  if (REG_WDATA > 16'h0001) begin
                     n.err = 1'b1;
                  end else begin
                     n.relay = REG_WDATA[0];
                  end
               end
               A_SAFE: begin
                  if (REG_WDATA > 16'h0001) begin
                     n.err = 1'b1;
                  end else begin
                     n.safe = REG_WDATA[0];
                  end
               end
               A_CLR_HI: begin
                  if (REG_WDATA > 16'h0001) begin
                     n.err = 1'b1;
                  end else if (REG_WDATA[0]) begin
                     n.hi = '0;
                  end
               end
               A_CLR_LO: begin
                  if (REG_WDATA > 16'h0001) begin
                     n.err = 1'b1;
                  end else if (REG_WDATA[0]) begin
                     n.lo = {N_SENSORS{LO_LATCH_RST}};
                  end
               end
               A_STATION: begin
                  if (REG_WDATA < STATION_MIN ||
                      REG_WDATA > STATION_MAX) begin
                     n.err = 1'b1;
                  end else begin
                     n.st_addr = REG_WDATA[7:0];
                  end
               end
               A_SERIAL: begin
                  if (REG_WDATA[15:8] != 8'h00 ||
                      REG_WDATA[5:0] < BAUD_CODE_MIN ||
                      REG_WDATA[5:0] > BAUD_CODE_MAX) begin
                     n.err = 1'b1;
                  end else begin
                     n.serial_pend = REG_WDATA[7:0];
                     n.pend = 1'b1;
                  end
               end
               A_RDLY: begin
                  if (REG_WDATA > RDLY_MAX) begin
                     n.err = 1'b1;
                  end else begin
                     n.rdly = REG_WDATA[4:0];
                  end
               end
               A_WD_TO: begin
                  if (REG_WDATA > WD_TO_MAX) begin
                     n.err = 1'b1;
                  end else begin
                     n.wd_to = REG_WDATA[7:0];
                  end
               end
               A_WD_CNT: begin
                  if (REG_WDATA != 16'h0000) begin
                     n.err = 1'b1;
                  end else begin
                     n.wd_cnt = 16'h0000;
                  end
               end
               A_THR: begin
                  if (REG_WDATA > THR_MAX) begin
                     n.err = 1'b1;
                  end else begin
                     n.thr = REG_WDATA[4:0];
                  end
               end
               A_BEEP: begin
                  if (REG_WDATA > BEEP_CONT) begin
                     n.err = 1'b1;
                  end else begin
                     n.beep_dur = REG_WDATA[7:0];
                  end
               end
               // Read-only and unmapped addresses
               default: n.err = 1'b1;
            endcase
         end else if (in_block(REG_ADDR, A_RES)) begin
            n.rdata = s.res[2'(REG_ADDR - A_RES)];
         end else if (in_block(REG_ADDR, A_HI)) begin
            n.rdata = s.hi[2'(REG_ADDR - A_HI)];
         end else if (in_block(REG_ADDR, A_LO)) begin
            n.rdata = s.lo[2'(REG_ADDR - A_LO)];
         end else begin
            unique case (REG_ADDR)
               A_RELAY: n.rdata = {15'h0000, s.relay};
               A_SAFE: n.rdata = {15'h0000, s.safe};
               A_SILENCE: n.rdata = {15'h0000, SILENCE_SW};
               A_POT: n.rdata = {11'h000, POT_INDEX};
               A_FW_LO: n.rdata = FW_VERSION[15:0];
               A_FW_HI: n.rdata = FW_VERSION[31:16];
               A_NAME_LO: n.rdata = MODULE_NAME[15:0];
               A_NAME_HI: n.rdata = MODULE_NAME[31:16];
               A_STATION: n.rdata = {8'h00, s.st_addr};
               A_SERIAL: n.rdata = {8'h00, s.serial_pend};
               A_RDLY: n.rdata = {11'h000, s.rdly};
               A_WD_TO: n.rdata = {8'h00, s.wd_to};
               A_WD_CNT: n.rdata = s.wd_cnt;
               A_THR: n.rdata = {11'h000, s.thr};
               A_BEEP: n.rdata = {8'h00, s.beep_dur};
               default: n.err = 1'b1;
            endcase
         end
      end

      // Swap only between frames; same-cycle write stays pending
      if (REPLY_DONE && s.pend) begin
         n.serial_act = s.serial_pend;
         n.pend = (n.serial_pend != s.serial_pend);
      end

      // Oversampling tick for the serial engine
      if (s.baud_cnt >= baud_div(s.serial_act[5:0])) begin
         n.baud_cnt = 13'h0000;
         n.baud_tick = 1'b1;
      end else begin
         n.baud_cnt = s.baud_cnt + 13'h0001;
      end

      n.match = (FRAME_ADDR == s.st_addr);
      n.cks = FRAME_FORMAT[FMT_CKS_BIT];

      // Reply delay, counted from the request itself
      unique case (s.rp)
         RP_IDLE: begin
            if (REPLY_READY) begin
               if (s.rdly == 5'h00) begin
                  n.reply_go = 1'b1;
               end else begin
                  n.rp = RP_WAIT;
                  n.rd_pre = 17'h00000;
                  n.rd_ms = 5'h00;
               end
            end
         end
         RP_WAIT: begin
            if (s.rd_pre == 17'(MS_CYC - 1)) begin
               n.rd_pre = 17'h00000;
               n.rd_ms = s.rd_ms + 5'h01;
               if (s.rd_ms + 5'h01 >= s.rdly) begin
                  n.reply_go = 1'b1;
                  n.rp = RP_IDLE;
               end
            end else begin
               n.rd_pre = s.rd_pre + 17'h00001;
            end
         end
      endcase

      // Host watchdog; expiry after clear still counts
      if (HOST_ACTIVITY) begin
         n.wd_steps = 8'h00;
         n.wd_exp = 1'b0;
      end else if (tick_step && s.wd_to != 8'h00 && !s.wd_exp) begin
         n.wd_steps = s.wd_steps + 8'h01;
         if (s.wd_steps + 8'h01 >= s.wd_to) begin
            n.wd_exp = 1'b1;
            if (n.wd_cnt != 16'hFFFF) begin
               n.wd_cnt = n.wd_cnt + 16'h0001;
            end
         end
      end

      // Latches see a reading even in a clear cycle
      if (SENSOR_VALID) begin
         n.res = SENSOR_RES;
         for (int i = 0; i < N_SENSORS; i++) begin
            if (SENSOR_RES[i] > n.hi[i]) begin
               n.hi[i] = SENSOR_RES[i];
            end
            if (SENSOR_RES[i] < n.lo[i]) begin
               n.lo[i] = SENSOR_RES[i];
            end
         end
      end

      // Timed beep starts on the alarm edge
      n.alarm_q = ALARM;
      if (ALARM && !s.alarm_q && s.beep_dur != 8'h00 &&
          16'(s.beep_dur) <= BEEP_MAX_TIMED) begin
         n.beep_left = s.beep_dur;
      end else if (tick_sec && s.beep_left != 8'h00) begin
         n.beep_left = s.beep_left - 8'h01;
      end
   end

   // ----------
   // Registers
   // ----------
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         s <= '0;
         s.st_addr <= STATION_RST;
         s.serial_act <= SERIAL_RST;
         s.serial_pend <= SERIAL_RST;
         s.lo <= {N_SENSORS{LO_LATCH_RST}};
         s.rp <= RP_IDLE;
      end else begin
         s <= n;
      end
   end

   // ----------
   // Outputs
   // ----------
   assign REG_ACK = s.ack;
   assign REG_ERR = s.err;
   assign REG_RDATA = s.rdata;
   assign FRAME_ADDR_MATCH = s.match;
   assign REPLY_GO = s.reply_go;
   assign BAUD_TICK = s.baud_tick;
   assign PARITY_EN = s.serial_act[7];
   assign PARITY_ODD = s.serial_act[7] & s.serial_act[6];
   assign STOP_TWO = s.serial_act[7:6] == 2'b01;
   assign CHECKSUM_EN = s.cks;
   assign WDOG_EXPIRED = s.wd_exp;
   assign LEAK_THRESHOLD = s.thr;
   // Silence switch mutes both beep modes
   assign BEEP = !SILENCE_SW &&
      ((16'(s.beep_dur) == BEEP_CONT && ALARM) ||
       s.beep_left != 8'h00);
   // Safe value takes over while the host is lost
   assign RELAY_OUT = s.wd_exp ? s.safe : s.relay;

endmodule

/* File: lms_regmap_asserts.sv */
`timescale 1ns/1ps
module lms_regmap_asserts
   import lms_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Register bus
   input wire logic REG_REQ,
   input wire logic REG_WE,
   input wire logic [15:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_ACK,
   input wire logic REG_ERR,
   // Frame, line and outputs
   input wire logic [7:0] FRAME_ADDR,
   input wire logic FRAME_ADDR_MATCH,
   input wire logic REPLY_GO,
   input wire logic [7:0] FRAME_FORMAT,
   input wire logic BAUD_TICK,
   input wire logic PARITY_EN,
   input wire logic PARITY_ODD,
   input wire logic STOP_TWO,
   input wire logic CHECKSUM_EN,
   input wire logic HOST_ACTIVITY,
   input wire logic WDOG_EXPIRED,
   input wire logic [4:0] LEAK_THRESHOLD,
   input wire logic SILENCE_SW,
   input wire logic BEEP
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);
   // ----------
   // Properties
   // ----------
   a_ack_on_req: assert property (REG_REQ |=> REG_ACK)
      else $error("no answer to request");
   a_ack_no_req: assert property (!REG_REQ |=> !REG_ACK)
      else $error("answer without request");
   a_err_with_ack: assert property (REG_ERR |-> REG_ACK)
      else $error("error outside answer");
   a_ro_write_err: assert property (REG_REQ && REG_WE &&
      (REG_ADDR == A_FW_LO || REG_ADDR == A_NAME_HI) |=> REG_ERR)
      else $error("read-only write accepted");
   a_station_bad: assert property (REG_REQ && REG_WE &&
      REG_ADDR == A_STATION && (REG_WDATA == 16'h0000 ||
      REG_WDATA > STATION_MAX) |=> REG_ERR)
      else $error("bad station accepted");
   a_thr_write: assert property (REG_REQ && REG_WE &&
      REG_ADDR == A_THR && REG_WDATA <= THR_MAX |=>
      LEAK_THRESHOLD == $past(REG_WDATA[4:0]))
      else $error("threshold not taken");
   a_addr_nomatch: assert property ((FRAME_ADDR == 8'h00 ||
      FRAME_ADDR > 8'hF7) |=> !FRAME_ADDR_MATCH)
      else $error("illegal station matched");
   a_cks_follow: assert property (1'b1 |=>
      CHECKSUM_EN == $past(FRAME_FORMAT[FMT_CKS_BIT]))
      else $error("checksum enable wrong");
   a_odd_format: assert property (PARITY_ODD |-> PARITY_EN && !STOP_TWO)
      else $error("odd format wrong");
   a_two_stops: assert property (STOP_TWO |-> !PARITY_EN)
      else $error("two stops with parity");
   a_tick_pulse: assert property (BAUD_TICK |=> !BAUD_TICK)
      else $error("baud tick too long");
   a_go_pulse: assert property (REPLY_GO |=> !REPLY_GO)
      else $error("reply go too long");
   a_wd_hold: assert property (WDOG_EXPIRED && !HOST_ACTIVITY |=>
      WDOG_EXPIRED)
      else $error("expiry dropped early");
   a_beep_mute: assert property (SILENCE_SW |-> !BEEP)
      else $error("beep while silenced");
endmodule

/* File: lms_regmap_bench.sv */
`timescale 1ns/1ps
module lms_regmap_bench;
   import lms_pkg::*;
   localparam int unsigned MSC = 4;
   // Identity words: values are arbitrary
   localparam logic [31:0] FWV = 32'h1234_5678;
   localparam logic [31:0] NMV = 32'h0000_0ABC;
   logic sys_clk = 1'b0, sys_rst = 1'b1, req = 1'b0, we = 1'b0;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, rd, sv;
   logic [7:0] frame_addr = 8'h00, ffmt = 8'h00;
   logic rdy = 1'b0, host_act = 1'b0, sens_v = 1'b0, alarm = 1'b0;
   logic sil = 1'b0, slow = 1'b0, er;
   logic [3:0][15:0] sens = '0;
   logic [4:0] pot = 5'h00, thr;
   logic ack, err, match, go, done, tick, par_en, par_odd, stop2, cks;
   logic wd_exp, beep, relay;
   int fail_count = 0, check_count = 0, n, p, v, pf = 0;
   int hi [4] = '{0, 0, 0, 0};
   int lo [4] = '{default: 65535};
   int last [4];
   int bt [8] = '{BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200,
      BAUD_38400, BAUD_57600, BAUD_115200};
   int dl [4] = '{0, 1, 2, 30};
   logic [15:0] ra [13] = '{A_STATION, A_SERIAL, A_RDLY, A_WD_TO, A_WD_CNT,
      A_THR, A_BEEP, A_RELAY, A_SAFE, A_FW_LO, A_FW_HI, A_NAME_LO, A_NAME_HI};
   logic [15:0] rv [13] = '{16'h0001, 16'h0006, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, FWV[15:0], FWV[31:16],
      NMV[15:0], NMV[31:16]};
   logic [15:0] ga [7] = '{A_STATION, A_RDLY, A_WD_TO, A_THR, A_BEEP,
      A_RELAY, A_SAFE};
   logic [15:0] gm [7] = '{STATION_MAX, RDLY_MAX, WD_TO_MAX, THR_MAX,
      BEEP_CONT, 16'h0001, 16'h0001};
   logic [15:0] oa [10] = '{A_FW_LO, A_FW_HI, A_NAME_LO, A_NAME_HI, A_RES,
      A_POT, A_HI, A_LO, A_SILENCE, 16'h1234};

   lms_regmap #(.MS_CYC(MSC), .FW_VERSION(FWV), .MODULE_NAME(NMV))
      lms_regmap_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .REG_REQ(req),
      .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_ACK(ack),
      .REG_ERR(err), .REG_RDATA(rdata), .FRAME_ADDR(frame_addr),
      .FRAME_ADDR_MATCH(match), .REPLY_READY(rdy), .REPLY_GO(go),
      .REPLY_DONE(done), .FRAME_FORMAT(ffmt), .BAUD_TICK(tick),
      .PARITY_EN(par_en), .PARITY_ODD(par_odd), .STOP_TWO(stop2),
      .CHECKSUM_EN(cks), .HOST_ACTIVITY(host_act), .WDOG_EXPIRED(wd_exp),
      .SENSOR_RES(sens), .SENSOR_VALID(sens_v), .POT_INDEX(pot),
      .LEAK_THRESHOLD(thr), .ALARM(alarm), .SILENCE_SW(sil), .BEEP(beep),
      .RELAY_OUT(relay));
   lms_host_model lms_host_model_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
      .REPLY_GO(go), .SLOW(slow), .REPLY_DONE(done));

   always #4 sys_clk = ~sys_clk;

   // ----------
   // Bus, compare and closing tasks
   // ----------
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chkb(string what, logic exp, logic got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic acc(logic w, logic [15:0] a, logic [15:0] d);
      @(posedge sys_clk);
      req <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk) req <= 1'b0;
      #1;
      chkb("answer", 1'b1, ack);
      rd = rdata;
      er = err;
   endtask
   task automatic wr(logic [15:0] a, logic [15:0] d, logic bad);
      acc(1'b1, a, d);
      chkb("write refused", bad, er);
   endtask
   task automatic rdc(logic [15:0] a, logic [15:0] exp);
      acc(1'b0, a, 16'h0000);
      chkb("read refused", 1'b0, er);
      chk("read data", exp, rd);
   endtask
   task automatic reply(output int cnt);
      @(posedge sys_clk) rdy <= 1'b1;
      cnt = 0;
      do begin
         @(posedge sys_clk) rdy <= (cnt == 2);
         cnt++;
         #1;
      end while (go !== 1'b1 && cnt < 500);
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic done_test(string s);
      $display("test %s done", s);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------
   // Test sequence
   // ----------
   initial begin
      void'($urandom(15714));
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      foreach (ra[i]) rdc(ra[i], rv[i]);
      chkb("parity reset", 1'b0, par_en);
      done_test("reset");
      wr(A_STATION, 16'h0000, 1'b1);
      wr(A_WD_CNT, 16'h0005, 1'b1);
      foreach (ga[i]) begin
         v = $urandom_range(gm[i], (ga[i] == A_STATION) ? 1 : 0);
         wr(ga[i], gm[i] + 16'h0001, 1'b1);
         wr(ga[i], 16'(v), 1'b0);
         rdc(ga[i], 16'(v));
         if (ga[i] == A_THR) chk("threshold", 16'(v), 16'(thr));
      end
      wr(A_WD_TO, 16'h0000, 1'b0);
      @(posedge sys_clk) host_act <= 1'b1;
      @(posedge sys_clk) host_act <= 1'b0;
      wr(A_WD_CNT, 16'h0000, 1'b0);
      foreach (oa[i]) wr(oa[i], 16'h0001, 1'b1);
      acc(1'b0, 16'h1234, 16'h0000);
      chkb("unmapped read", 1'b1, er);
      done_test("ranges");
      wr(A_SERIAL, 16'h0002, 1'b1);
      wr(A_SERIAL, 16'h0106, 1'b1);
      wr(A_RDLY, 16'h0000, 1'b0);
      for (int c = 3; c <= 10; c++) begin
         sv = 16'((c % 4) * 64 + c);
         slow <= c[0];
         wr(A_SERIAL, sv, 1'b0);
         rdc(A_SERIAL, sv);
         chkb("format held", pf >= 2, par_en);
         reply(n);
         cyc(25);
         pf = c % 4;
         chkb("parity on", pf >= 2, par_en);
         chkb("parity odd", pf == 3, par_odd);
         chkb("two stops", pf == 1, stop2);
         for (n = 0; tick !== 1'b1 && n < 9000; n++) cyc(1);
         cyc(1);
         for (n = 1; tick !== 1'b1 && n < 9000; n++) cyc(1);
         p = CLK_HZ / (OVERSAMPLE * bt[c - 3]);
         chk("baud period", 16'(p), 16'(n));
      end
      @(posedge sys_clk) ffmt <= 8'h40;
      cyc(2);
      chkb("checksum on", 1'b1, cks);
      @(posedge sys_clk) ffmt <= 8'h00;
      cyc(2);
      chkb("checksum off", 1'b0, cks);
      done_test("serial");
      foreach (dl[i]) begin
         wr(A_RDLY, 16'(dl[i]), 1'b0);
         reply(n);
         chk("reply delay", 16'(dl[i] == 0 ? 1 : dl[i] * MSC + 1), 16'(n));
         cyc(25);
      end
      v = $urandom_range(247, 1);
      wr(A_STATION, 16'(v), 1'b0);
      @(posedge sys_clk) frame_addr <= 8'(v);
      cyc(2);
      chkb("own station", 1'b1, match);
      @(posedge sys_clk) frame_addr <= 8'(v + 1);
      cyc(2);
      chkb("other station", 1'b0, match);
      done_test("frame");
      for (int k = 0; k < 6; k++) begin
         @(posedge sys_clk);
         for (int i = 0; i < 4; i++) begin
            v = $urandom_range(65535);
            sens[i] <= 16'(v);
            last[i] = v;
            if (v > hi[i]) hi[i] = v;
            if (v < lo[i]) lo[i] = v;
         end
         sens_v <= 1'b1;
         @(posedge sys_clk) sens_v <= 1'b0;
      end
      @(posedge sys_clk) pot <= 5'($urandom_range(24));
      cyc(2);
      rdc(A_POT, {11'h000, pot});
      for (int i = 0; i < 4; i++) begin
         rdc(A_RES + 16'(i), 16'(last[i]));
         rdc(A_HI + 16'(i), 16'(hi[i]));
         rdc(A_LO + 16'(i), 16'(lo[i]));
      end
      wr(A_CLR_HI, 16'h0001, 1'b0);
      wr(A_CLR_LO, 16'h0001, 1'b0);
      for (int i = 0; i < 4; i++) begin
         rdc(A_HI + 16'(i), 16'h0000);
         rdc(A_LO + 16'(i), 16'hFFFF);
      end
      done_test("latches");
      wr(A_RELAY, 16'h0001, 1'b0);
      wr(A_SAFE, 16'h0001, 1'b0);
      chkb("relay on", 1'b1, relay);
      wr(A_RELAY, 16'h0000, 1'b0);
      chkb("relay off", 1'b0, relay);
      wr(A_WD_TO, 16'h0001, 1'b0);
      for (n = 0; wd_exp !== 1'b1 && n < 300 * MSC; n++) cyc(1);
      chkb("expired", 1'b1, wd_exp);
      chkb("safe relay", 1'b1, relay);
      rdc(A_WD_CNT, 16'h0001);
      wr(A_WD_TO, 16'h0000, 1'b0);
      wr(A_WD_CNT, 16'h0000, 1'b0);
      rdc(A_WD_CNT, 16'h0000);
      @(posedge sys_clk) host_act <= 1'b1;
      @(posedge sys_clk) host_act <= 1'b0;
      cyc(2);
      chkb("expiry gone", 1'b0, wd_exp);
      chkb("live relay", 1'b0, relay);
      done_test("relay");
      wr(A_BEEP, BEEP_CONT, 1'b0);
      @(posedge sys_clk) alarm <= 1'b1;
      cyc(2);
      chkb("beep on", 1'b1, beep);
      @(posedge sys_clk) sil <= 1'b1;
      cyc(2);
      chkb("beep muted", 1'b0, beep);
      rdc(A_SILENCE, 16'h0001);
      @(posedge sys_clk) sil <= 1'b0;
      wr(A_BEEP, 16'h0000, 1'b0);
      cyc(2);
      chkb("beep off", 1'b0, beep);
      wr(A_BEEP, 16'h0002, 1'b0);
      @(posedge sys_clk) alarm <= 1'b0;
      @(posedge sys_clk) alarm <= 1'b1;
      cyc(2);
      chkb("timed beep", 1'b1, beep);
      cyc(2 * SEC_STEPS * WD_STEP_MS * MSC);
      chkb("timed beep over", 1'b0, beep);
      done_test("beep");
      final_report();
   end

   initial begin
      repeat (80000) @(posedge sys_clk);
      fail_count++;
      final_report();
   end
endmodule

bind lms_regmap lms_regmap_asserts lms_regmap_asserts_inst (
   .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_REQ(REG_REQ), .REG_WE(REG_WE),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK),
   .REG_ERR(REG_ERR), .FRAME_ADDR(FRAME_ADDR),
   .FRAME_ADDR_MATCH(FRAME_ADDR_MATCH), .REPLY_GO(REPLY_GO),
   .FRAME_FORMAT(FRAME_FORMAT), .BAUD_TICK(BAUD_TICK), .PARITY_EN(PARITY_EN),
   .PARITY_ODD(PARITY_ODD), .STOP_TWO(STOP_TWO), .CHECKSUM_EN(CHECKSUM_EN),
   .HOST_ACTIVITY(HOST_ACTIVITY), .WDOG_EXPIRED(WDOG_EXPIRED),
   .LEAK_THRESHOLD(LEAK_THRESHOLD), .SILENCE_SW(SILENCE_SW), .BEEP(BEEP));
